/* pkg/grcs_defs.svh */
// Purpose: Constants of the gain ranging channel sequencer
// Assumes: core_clk at 125 MHz
// Notes: Times in ns, cycle counts derived from them
`ifndef GRCS_DEFS_SVH
`define GRCS_DEFS_SVH

// Clock and encode timing
`define GRCS_CLK_MHZ 125
`define GRCS_ENC_PERIOD_NS 50
// Quarter encode period, rounded down, never below one cycle
`define GRCS_QTR_RAW ((`GRCS_ENC_PERIOD_NS * `GRCS_CLK_MHZ) / 4000)
`define GRCS_QTR_CYC ((`GRCS_QTR_RAW < 1) ? 1 : `GRCS_QTR_RAW)

// Range codes and field positions
`define GRCS_RANGE_W 3
`define GRCS_RANGE_MAX 3'h5
`define GRCS_RANGE_RST 3'h0
`define GRCS_ATT_MSB 2
`define GRCS_ATT_LSB 1
`define GRCS_GAIN_BIT 0

// Attenuator settings: 0 dB, -12 dB, -24 dB
`define GRCS_ATT_0DB 2'h0
`define GRCS_ATT_12DB 2'h1
`define GRCS_ATT_24DB 2'h2

// Lowest rising threshold; each higher one is 6 dB above
`define GRCS_THR_BASE 12'h040

`endif

/* pkg/grcs_pkg.sv */
// Purpose: Types of the gain ranging channel sequencer
// Assumes: Nothing
// Notes: One-hot codes written out
package grcs_pkg;

  // Operating mode from the straps
  typedef enum logic [3:0] {
    GRCS_MODE_NONE = 4'h1,
    GRCS_MODE_A = 4'h2,
    GRCS_MODE_B = 4'h4,
    GRCS_MODE_DUAL = 4'h8
  } grcs_mode_t;

  // Phase within one encode period
  typedef enum logic [3:0] {
    GRCS_PH_IDLE = 4'h1,
    GRCS_PH_CAL = 4'h2,
    GRCS_PH_HOLDOFF = 4'h4,
    GRCS_PH_SETTLE = 4'h8
  } grcs_phase_t;

endpackage

/* pkg/grcs_rng_if.sv */
// Purpose: Link between sequencer and one channel range decision
// Assumes: Same clock on both sides
// Notes: update is a one-cycle strobe
`timescale 1ns/1ps
interface grcs_rng_if #(parameter int ENV_W = 12);
  logic [ENV_W-1:0] peak;
  logic update;
  logic [2:0] code;

  modport ctl (input peak, input update, output code);
  modport seq (output peak, output update, input code);
endinterface

/* logic/grcs_range_ctrl.sv */
// Purpose: Range decision with 6 dB hysteresis for one channel
// Assumes: peak is the envelope maximum of the last calibration
// Notes: Code grows with signal; 0 is most gain, 5 least
`timescale 1ns/1ps
`include "grcs_defs.svh"
module grcs_range_ctrl
  import grcs_pkg::*;
#(
  parameter int ENV_W = 12
)
(
  input wire logic core_clk,
  input wire logic rstn,
  grcs_rng_if.ctl rng
);

  logic [4:0] up_hit;
  logic [4:0] dn_hit;
  logic [2:0] up_tgt;
  logic [2:0] dn_tgt;
  logic [2:0] code_reg;
  logic [2:0] code_next;

  ////////////////////////////////////////////////////////////////////////
  // Threshold ladder, one rung per 6 dB step
  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_rung
      localparam logic [ENV_W-1:0] THR_UP = ENV_W'(`GRCS_THR_BASE) << k;
      assign up_hit[k] = rng.peak >= THR_UP;
      assign dn_hit[k] = rng.peak >= (THR_UP >> 1);
    end
  endgenerate

  // Count rungs passed in each direction
  always_comb
  begin
    up_tgt = 3'h0;
    dn_tgt = 3'h0;
    for (int i = 0; i < 5; i++)
    begin
      up_tgt = up_tgt + {2'h0, up_hit[i]};
      dn_tgt = dn_tgt + {2'h0, dn_hit[i]};
    end
  end

  // Rise on upper threshold, fall only below lower one
  always_comb
  begin
    code_next = code_reg;
    if (up_tgt > code_reg)
      code_next = up_tgt;
    else if (dn_tgt < code_reg)
      code_next = dn_tgt;
  end

  // Range held until the next calibration end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      code_reg <= `GRCS_RANGE_RST;
    else if (rng.update)
      code_reg <= code_next;
  end

  assign rng.code = code_reg;

endmodule

/* logic/grcs_sequencer.sv */
// Contract
// - Three attenuator steps: 0, -12, -24 dB.
// - Gain stage after mux: 12 or 18 dB.
// - Six ranges, -12 to +18 dB, 6 dB apart.
// - Range codes 000 to 101 as tabled.
// - Mux routes channel A or B by mode.
// - Range measured one sample ahead of conversion.
// - Hysteresis thresholds exactly 6 dB apart.
// - Settings applied after calibration, before hold.
// - Dual mode measures one channel, converts other.
// - Encode edge holds sample, resets peak detector.
// - Quarter-period calibration, filter discharged, amp off.
// - Amp re-enabled a quarter period after calibration.
// - Dual alternates channels; single repeats one.
// - Indicator 1 for A, 0 for B, per word.
// - Range updated every encode cycle.
// - Output 11-bit mantissa with 3-bit offset-binary exponent.
// Purpose: Encode-cycle control of a dual-input gain-ranging front end
// Assumes: Encode and straps arrive as pins; envelopes and mantissa on core_clk
// Notes: One range decision module per channel
`timescale 1ns/1ps
`include "grcs_defs.svh"
module grcs_sequencer
  import grcs_pkg::*;
#(
  parameter int ENV_W = 12,
  parameter int QTR_CYC = `GRCS_QTR_CYC
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic enc_pin,
  input wire logic sel_a_pin,
  input wire logic sel_b_pin,
  input wire logic [ENV_W-1:0] env_a,
  input wire logic [ENV_W-1:0] env_b,
  input wire logic [10:0] adc_mantissa,
  output logic [1:0] att_a_sel,
  output logic [1:0] att_b_sel,
  output logic gain_high,
  output logic mux_sel_b,
  output logic th_hold,
  output logic peak_init,
  output logic filter_discharge,
  output logic filter_amp_en,
  output logic [10:0] data_out,
  output logic [2:0] range_out,
  output logic output_channel_indicator,
  output logic data_valid,
  output logic dual_mode,
  output logic config_error
);

  logic [2:0] enc_sync_reg;
  logic [2:0] sela_sync_reg;
  logic [2:0] selb_sync_reg;
  logic enc_lvl_reg;
  logic sela_lvl_reg;
  logic selb_lvl_reg;
  logic enc_rise;
  grcs_mode_t mode;
  grcs_phase_t phase_reg;
  logic [7:0] cnt_reg;
  logic meas_b_reg;
  logic [ENV_W-1:0] peak_reg;
  logic [ENV_W-1:0] env_meas;
  logic [1:0] upd_reg;
  logic [2:0] meas_code;
  logic conv_b_reg;
  logic [2:0] conv_code_reg;
  logic primed_reg;
  logic th_hold_reg;
  logic [10:0] data_reg;
  logic [2:0] range_reg;
  logic ind_reg;
  logic valid_reg;
  logic [1:0] att_a_reg;
  logic [1:0] att_b_reg;
  logic gain_high_reg;

  grcs_rng_if #(.ENV_W(ENV_W)) rng_bus[2] ();

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; level moves once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enc_sync_reg <= 3'h0;
      sela_sync_reg <= 3'h0;
      selb_sync_reg <= 3'h0;
    end
    else
    begin
      enc_sync_reg <= {enc_sync_reg[1:0], enc_pin};
      sela_sync_reg <= {sela_sync_reg[1:0], sel_a_pin};
      selb_sync_reg <= {selb_sync_reg[1:0], sel_b_pin};
    end
  end

  // Filtered levels
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enc_lvl_reg <= 1'b0;
      sela_lvl_reg <= 1'b0;
      selb_lvl_reg <= 1'b0;
    end
    else
    begin
      if (enc_sync_reg[1] == enc_sync_reg[2])
        enc_lvl_reg <= enc_sync_reg[2];
      if (sela_sync_reg[1] == sela_sync_reg[2])
        sela_lvl_reg <= sela_sync_reg[2];
      if (selb_sync_reg[1] == selb_sync_reg[2])
        selb_lvl_reg <= selb_sync_reg[2];
    end
  end

  assign enc_rise = enc_sync_reg[1] & enc_sync_reg[2] & ~enc_lvl_reg;

  // Mode decode from the straps
  always_comb
  begin
    case ({sela_lvl_reg, selb_lvl_reg})
      2'b11: mode = GRCS_MODE_DUAL;
      2'b10: mode = GRCS_MODE_A;
      2'b01: mode = GRCS_MODE_B;
      default: mode = GRCS_MODE_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase within the encode period, restarted by every encode edge
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_reg <= GRCS_PH_IDLE;
      cnt_reg <= 8'h0;
    end
    else if (enc_rise)
    begin
      phase_reg <= GRCS_PH_CAL;
      cnt_reg <= 8'h0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h1;
      case (phase_reg)
        GRCS_PH_CAL:
          if (cnt_reg == 8'(QTR_CYC - 1))
          begin
            phase_reg <= GRCS_PH_HOLDOFF;
            cnt_reg <= 8'h0;
          end
        GRCS_PH_HOLDOFF:
          if (cnt_reg == 8'(QTR_CYC - 1))
          begin
            phase_reg <= GRCS_PH_SETTLE;
            cnt_reg <= 8'h0;
          end
        GRCS_PH_SETTLE, GRCS_PH_IDLE: cnt_reg <= 8'h0;
        default: phase_reg <= GRCS_PH_IDLE;
      endcase
    end
  end

  // Filter node and its driver follow the phase
  assign filter_discharge = (phase_reg == GRCS_PH_CAL);
  assign filter_amp_en = (phase_reg == GRCS_PH_SETTLE);

  ////////////////////////////////////////////////////////////////////////
  // Channel under measurement toggles each encode edge in dual mode, fixed by the strap in single mode
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      meas_b_reg <= 1'b0;
    else if (enc_rise)
    begin
      case (mode)
        GRCS_MODE_DUAL: meas_b_reg <= ~meas_b_reg;
        GRCS_MODE_A: meas_b_reg <= 1'b0;
        GRCS_MODE_B: meas_b_reg <= 1'b1;
        default: meas_b_reg <= 1'b0;
      endcase
    end
  end

  assign mux_sel_b = meas_b_reg;
  assign env_meas = meas_b_reg ? env_b : env_a;

  // Peak detector, cleared by the encode edge, tracks during calibration
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      peak_reg <= '0;
    else if (enc_rise)
      peak_reg <= '0;
    else if (phase_reg == GRCS_PH_CAL && env_meas > peak_reg)
      peak_reg <= env_meas;
  end

  // Range update strobe at calibration end, per measured channel
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      upd_reg <= 2'h0;
    else if (phase_reg == GRCS_PH_CAL && cnt_reg == 8'(QTR_CYC - 1) && !enc_rise)
      upd_reg <= meas_b_reg ? 2'b10 : 2'b01;
    else
      upd_reg <= 2'h0;
  end

  // One range decision per channel
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      assign rng_bus[c].peak = peak_reg;
      assign rng_bus[c].update = upd_reg[c];
      grcs_range_ctrl #(.ENV_W(ENV_W)) u_range (
        .core_clk(core_clk),
        .rstn(rstn),
        .rng(rng_bus[c])
      );
    end
  endgenerate

  assign meas_code = meas_b_reg ? rng_bus[1].code : rng_bus[0].code;

  // Attenuators per channel, shared gain from the routed channel
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      att_a_reg <= `GRCS_ATT_0DB;
      att_b_reg <= `GRCS_ATT_0DB;
      gain_high_reg <= 1'b1;
    end
    else
    begin
      att_a_reg <= rng_bus[0].code[`GRCS_ATT_MSB:`GRCS_ATT_LSB];
      att_b_reg <= rng_bus[1].code[`GRCS_ATT_MSB:`GRCS_ATT_LSB];
      gain_high_reg <= ~meas_code[`GRCS_GAIN_BIT];
    end
  end

  assign att_a_sel = att_a_reg;
  assign att_b_sel = att_b_reg;
  assign gain_high = gain_high_reg;

  ////////////////////////////////////////////////////////////////////////
  // Encode edge: hold pulse, peak reset, output word of prior sample
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      th_hold_reg <= 1'b0;
      conv_b_reg <= 1'b0;
      conv_code_reg <= `GRCS_RANGE_RST;
      primed_reg <= 1'b0;
      data_reg <= 11'h0;
      range_reg <= `GRCS_RANGE_RST;
      ind_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      th_hold_reg <= enc_rise;
      valid_reg <= 1'b0;
      if (enc_rise)
      begin
        data_reg <= adc_mantissa;
        range_reg <= conv_code_reg;
        ind_reg <= ~conv_b_reg;
        valid_reg <= primed_reg && (mode != GRCS_MODE_NONE);
        conv_b_reg <= meas_b_reg;
        conv_code_reg <= meas_code;
        primed_reg <= (phase_reg == GRCS_PH_SETTLE);
      end
    end
  end

  assign th_hold = th_hold_reg;
  assign peak_init = th_hold_reg;
  assign data_out = data_reg;
  assign range_out = range_reg;
  assign output_channel_indicator = ind_reg;
  assign data_valid = valid_reg;
  assign dual_mode = (mode == GRCS_MODE_DUAL);
  assign config_error = (mode == GRCS_MODE_NONE);

endmodule

/* sim/grcs_seq_chk.sv */
// Purpose: Port checks of the sequencer
// Assumes: QTR_CYC equals the design value
// Notes: Bound after the module
`timescale 1ns/1ps
module grcs_seq_chk
#(
  parameter int QTR_CYC = 1
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic th_hold,
  input wire logic peak_init,
  input wire logic filter_discharge,
  input wire logic filter_amp_en,
  input wire logic data_valid,
  input wire logic output_channel_indicator,
  input wire logic dual_mode,
  input wire logic config_error,
  input wire logic [2:0] range_out,
  input wire logic [1:0] att_a_sel,
  input wire logic [10:0] data_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic prev_reg;
  logic seen_reg;
  // Channel of the last word
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else if (data_valid)
    begin
      prev_reg <= output_channel_indicator;
      seen_reg <= 1'b1;
    end
  ////////////////////////////////////////////////////////////////
  sequence s_cal; filter_discharge && !filter_amp_en; endsequence
  sequence s_off; !filter_discharge && !filter_amp_en; endsequence
  property p_pair; th_hold == peak_init; endproperty
  a_pair: assert property (p_pair)
    else $error("hold and init differ");
  property p_pulse; th_hold |=> !th_hold; endproperty
  a_pulse: assert property (p_pulse)
    else $error("hold longer than one cycle");
  property p_phase; th_hold |-> s_cal ##QTR_CYC s_off ##QTR_CYC filter_amp_en; endproperty
  a_phase: assert property (p_phase)
    else $error("calibration phases wrong");
  property p_vld; data_valid |-> th_hold; endproperty
  a_vld: assert property (p_vld)
    else $error("word outside encode");
  property p_err; config_error |-> !data_valid && !dual_mode; endproperty
  a_err: assert property (p_err)
    else $error("word with bad straps");
  property p_codes; range_out <= 3'h5 && att_a_sel != 2'h3; endproperty
  a_codes: assert property (p_codes)
    else $error("code out of range");
  property p_stand; !th_hold |-> $stable(data_out) && $stable(range_out); endproperty
  a_stand: assert property (p_stand)
    else $error("word changed mid period");
  property p_alt;
    data_valid && seen_reg |-> output_channel_indicator == (dual_mode ? !prev_reg : prev_reg);
  endproperty
  a_alt: assert property (p_alt)
    else $error("channel order wrong");
endmodule
bind grcs_sequencer grcs_seq_chk #(.QTR_CYC(QTR_CYC)) i_grcs_seq_chk (
  .core_clk(core_clk), .rstn(rstn), .th_hold(th_hold), .peak_init(peak_init),
  .filter_discharge(filter_discharge), .filter_amp_en(filter_amp_en),
  .data_valid(data_valid), .output_channel_indicator(output_channel_indicator),
  .dual_mode(dual_mode), .config_error(config_error), .range_out(range_out),
  .att_a_sel(att_a_sel), .data_out(data_out));

/* sim/grcs_rx_model.sv */
// Purpose: Downstream receiver of sample words
// Assumes: One word per data_valid pulse
// Notes: Rebuilds the 16-bit value
`timescale 1ns/1ps
module grcs_rx_model
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic data_valid,
  input wire logic [10:0] data_out,
  input wire logic [2:0] range_out,
  input wire logic output_channel_indicator,
  output logic [7:0] a_cnt,
  output logic [7:0] b_cnt,
  output logic [2:0] a_rng,
  output logic [2:0] b_rng,
  output logic [15:0] full_word
);
  // Sort words by channel, shift by exponent
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      a_cnt <= 8'h0;
      b_cnt <= 8'h0;
      a_rng <= 3'h0;
      b_rng <= 3'h0;
      full_word <= 16'h0;
    end
    else if (data_valid)
    begin
      full_word <= {{5{data_out[10]}}, data_out} << range_out;
      if (output_channel_indicator)
      begin
        a_cnt <= a_cnt + 8'h1;
        a_rng <= range_out;
      end
      else
      begin
        b_cnt <= b_cnt + 8'h1;
        b_rng <= range_out;
      end
    end
endmodule

/* sim/tb_grcs_sequencer.sv */
// Purpose: Bench of the sequencer
// Assumes: QTR_CYC of one cycle
// Notes: Straps set under reset
`timescale 1ns/1ps
module tb_grcs_sequencer;
  logic core_clk, rstn = 1'h0, enc_pin = 1'h0, sel_a_pin = 1'h0, sel_b_pin = 1'h0;
  logic [11:0] env_a = 12'h000, env_b = 12'h000;
  logic [10:0] mant = 11'h000, data_out;
  logic [1:0] att_a_sel, att_b_sel;
  logic [2:0] range_out, a_rng, b_rng;
  logic [7:0] a_cnt, b_cnt;
  logic [15:0] full_word;
  logic gain_high, mux_sel_b, th_hold, peak_init, filter_discharge, filter_amp_en;
  logic output_channel_indicator, data_valid, dual_mode, config_error;
  int num_errors = 0, check_count = 0, cycles = 0;
  logic [11:0] lv [9] = '{12'h000, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400,
    12'h200, 12'h100, 12'h200};
  logic [2:0] ex [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h4, 3'h4};
  grcs_sequencer i_grcs_sequencer (.core_clk(core_clk), .rstn(rstn), .enc_pin(enc_pin),
    .sel_a_pin(sel_a_pin), .sel_b_pin(sel_b_pin), .env_a(env_a), .env_b(env_b),
    .adc_mantissa(mant), .att_a_sel(att_a_sel), .att_b_sel(att_b_sel),
    .gain_high(gain_high), .mux_sel_b(mux_sel_b), .th_hold(th_hold),
    .peak_init(peak_init), .filter_discharge(filter_discharge),
    .filter_amp_en(filter_amp_en), .data_out(data_out), .range_out(range_out),
    .output_channel_indicator(output_channel_indicator), .data_valid(data_valid),
    .dual_mode(dual_mode), .config_error(config_error));
  grcs_rx_model i_grcs_rx_model (.core_clk(core_clk), .rstn(rstn),
    .data_valid(data_valid), .data_out(data_out), .range_out(range_out),
    .output_channel_indicator(output_channel_indicator), .a_cnt(a_cnt),
    .b_cnt(b_cnt), .a_rng(a_rng), .b_rng(b_rng), .full_word(full_word));
  ////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // Reset with straps tied
  task mode(input logic a, input logic b);
    @(negedge core_clk) rstn = 0;
    sel_a_pin = a;
    sel_b_pin = b;
    repeat (12) @(negedge core_clk);
    rstn = 1;
    repeat (6) @(negedge core_clk);
  endtask
  // Encode periods of 20 cycles
  task enc(input int n);
    repeat (n)
    begin
      @(negedge core_clk) enc_pin = 1;
      repeat (10) @(negedge core_clk);
      enc_pin = 0;
      repeat (9) @(negedge core_clk);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    mode(1'b1, 1'b0);
    mant = 11'h3ff;
    for (int i = 0; i < 9; i++)
    begin
      env_a = lv[i];
      enc(4);
      chk(16'(range_out), 16'(ex[i]), "range");
      chk(16'(att_a_sel), 16'(ex[i][2:1]), "att");
      chk(16'(gain_high), 16'(!ex[i][0]), "gain");
    end
    chk(16'(data_out), 16'h03ff, "data");
    chk(full_word, 16'h3ff0, "word");
    chk(16'(mux_sel_b), 16'h0, "mux");
    $display("test single A done");
    mode(1'b1, 1'b1);
    env_a = 12'h400;
    env_b = 12'h000;
    enc(12);
    chk(16'(dual_mode), 16'h1, "dual");
    chk(16'(a_rng), 16'h5, "a range");
    chk(16'(b_rng), 16'h0, "b range");
    chk(16'(a_cnt > 8'h4 && b_cnt > 8'h4), 16'h1, "both");
    chk(16'(att_a_sel), 16'h2, "att a");
    chk(16'(att_b_sel), 16'h0, "att b");
    $display("test dual done");
    mode(1'b0, 1'b1);
    env_b = 12'h100;
    mant = 11'h401;
    enc(6);
    chk(16'(range_out), 16'h3, "range b");
    chk(16'(att_b_sel), 16'h1, "att b");
    chk(16'(gain_high), 16'h0, "gain b");
    chk(16'(mux_sel_b), 16'h1, "mux b");
    chk(16'(data_out), 16'h0401, "data b");
    chk(full_word, 16'he008, "word b");
    $display("test single B done");
    mode(1'b0, 1'b0);
    enc(5);
    chk(16'(config_error), 16'h1, "error");
    chk(16'(a_cnt) + 16'(b_cnt), 16'h0, "no words");
    $display("test no straps done");
    give_verdict;
  end
endmodule
